// ==== core/cis_branch_calc.sv ====
// Branch target adder: signed offset added to the advanced program counter.
`timescale 1ns/1ps
`default_nettype none
module cis_branch_calc #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0] pc_after,
  input  wire logic [7:0]        offset,
  input  wire logic              take,
  output logic      [ADDR_W-1:0] pc_next
);
  wire logic [ADDR_W-1:0] offset_ext = {{(ADDR_W-8){offset[7]}}, offset};
  wire logic [ADDR_W-1:0] target     = ADDR_W'(pc_after + offset_ext);
  // pc_after already points past the whole branch, so fall-through is free
  assign pc_next = take ? target : pc_after;
endmodule
`default_nettype wire

// ==== core/cis_pkg.sv ====
// Package for the instruction cycle sequencer: opcodes, widths, reset values.
package cis_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OP_STORE_DIR    = 8'hb7;
  localparam logic [7:0]  OP_LOAD_IMM     = 8'ha6;
  localparam logic [7:0]  OP_BRANCH_PLUS  = 8'h2a;
  // Bit-test branches: 0000_bbb0 = branch if bit set, 0000_bbb1 = branch if bit clear
  localparam logic [3:0]  OP_BITBR_HI     = 4'h0;
  localparam logic [7:0]  DIRECT_PAGE     = 8'h00;
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [4:0]  FLAGS_RESET     = 5'h00;
  localparam int          FLAG_N_POS      = 2;
  localparam int          FLAG_Z_POS      = 1;

  typedef enum logic [3:0] {
    CIS_FETCH   = 4'b0000,
    CIS_STA_LO  = 4'b0001,
    CIS_STA_BLD = 4'b0010,
    CIS_STA_WR  = 4'b0011,
    CIS_LDA_IMM = 4'b0100,
    CIS_BR_OFS  = 4'b0101,
    CIS_BR_EXE  = 4'b0110,
    CIS_BT_ADR  = 4'b0111,
    CIS_BT_RD   = 4'b1000,
    CIS_BT_OFS  = 4'b1001,
    CIS_BT_EXE  = 4'b1010,
    CIS_HALT    = 4'b1011
  } cis_state_e;
endpackage

// ==== core/cis_sequencer.sv ====
// Cycle sequencer for store-direct, load-immediate and conditional branch instructions.
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer
  import cis_pkg::*;
#(
  parameter int AW = cis_pkg::ADDR_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic [cis_pkg::DATA_W-1:0] mem_rdata,
  output logic      [AW-1:0]            bus_addr,
  output logic      [cis_pkg::DATA_W-1:0] bus_wdata,
  output logic                          bus_write,
  output logic                          bus_read,
  output logic      [7:0]               acc,
  output logic      [4:0]               condition_flags_reg,
  output logic      [AW-1:0]            pc,
  output logic                          unknown_op
);
  import cis_pkg::*;

  cis_state_e  state;
  cis_state_e  next_state;
  logic [7:0]  opcode;
  logic [7:0]  addr_lo;
  logic [7:0]  test_byte;
  logic [7:0]  offset;

  // Opcode decode
  wire logic is_store      = (mem_rdata == OP_STORE_DIR);
  wire logic is_load       = (mem_rdata == OP_LOAD_IMM);
  wire logic is_plus       = (mem_rdata == OP_BRANCH_PLUS);
  wire logic is_bittest    = (mem_rdata[7:4] == OP_BITBR_HI);
  wire logic [2:0] bit_sel = opcode[3:1];
  wire logic want_clear    = opcode[0];
  wire logic sel_bit       = test_byte[bit_sel];
  wire logic [AW-1:0] pc_inc = AW'(pc + 1'b1);
  wire logic [AW-1:0] direct_addr = {{(AW-16){1'b0}}, DIRECT_PAGE, addr_lo};

  // Condition of the pending branch
  wire logic plus_take   = ~condition_flags_reg[FLAG_N_POS];
  wire logic bit_take    = want_clear ? ~sel_bit : sel_bit;
  wire logic branch_take = (state == CIS_BT_EXE) ? bit_take : plus_take;
  wire logic [AW-1:0] branch_pc;

  cis_branch_calc #(
    .ADDR_W (AW)
  ) u_calc (
    .pc_after (pc),
    .offset   (offset),
    .take     (branch_take),
    .pc_next  (branch_pc)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      CIS_FETCH: begin
        if (is_store)
          next_state = CIS_STA_LO;
        else if (is_load)
          next_state = CIS_LDA_IMM;
        else if (is_plus)
          next_state = CIS_BR_OFS;
        else if (is_bittest)
          next_state = CIS_BT_ADR;
        else
          next_state = CIS_HALT;
      end
      CIS_STA_LO:  next_state = CIS_STA_BLD;
      CIS_STA_BLD: next_state = CIS_STA_WR;
      CIS_STA_WR:  next_state = CIS_FETCH;
      CIS_LDA_IMM: next_state = CIS_FETCH;
      CIS_BR_OFS:  next_state = CIS_BR_EXE;
      CIS_BR_EXE:  next_state = CIS_FETCH;
      CIS_BT_ADR:  next_state = CIS_BT_RD;
      CIS_BT_RD:   next_state = CIS_BT_OFS;
      CIS_BT_OFS:  next_state = CIS_BT_EXE;
      CIS_BT_EXE:  next_state = CIS_FETCH;
      CIS_HALT:    next_state = CIS_HALT;
      default:     next_state = CIS_HALT;
    endcase
  end

  // Program counter for the coming cycle; each fetched byte but an opcode that leads to CIS_HALT advances it exactly once.
  // The bus address is taken from it too, so the operand fetch never repeats the opcode address.
  logic [AW-1:0] next_pc;
  always_comb begin
    next_pc = pc;
    unique case (state)
      CIS_FETCH:   if (next_state != CIS_HALT) next_pc = pc_inc;
      CIS_STA_LO:  next_pc = pc;
      CIS_STA_BLD: next_pc = pc_inc;
      CIS_LDA_IMM: next_pc = pc_inc;
      CIS_BR_OFS:  next_pc = pc_inc;
      CIS_BT_ADR:  next_pc = pc_inc;
      CIS_BT_OFS:  next_pc = pc_inc;
      CIS_BR_EXE, CIS_BT_EXE: next_pc = branch_pc;
      default:     next_pc = pc;
    endcase
  end

  // Bus outputs for the coming cycle, registered so every port is a flop
  logic [AW-1:0] next_addr;
  logic          next_write;
  logic          next_read;
  always_comb begin
    next_addr  = next_pc;
    next_write = 1'b0;
    next_read  = 1'b1;
    unique case (next_state)
      CIS_STA_BLD: next_read = 1'b0;
      CIS_STA_WR: begin
        next_addr  = {{(AW-16){1'b0}}, DIRECT_PAGE, addr_lo};
        next_write = 1'b1;
        next_read  = 1'b0;
      end
      CIS_BT_RD:  next_read = 1'b1;
      CIS_BR_EXE, CIS_BT_EXE, CIS_HALT: next_read = 1'b0;
      default: ;
    endcase
  end

  // Address low byte arrives in CIS_BT_ADR; bus then points at it
  wire logic [AW-1:0] bt_addr = {{(AW-16){1'b0}}, DIRECT_PAGE, mem_rdata};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state     <= CIS_FETCH;
      bus_addr  <= PC_RESET;
      bus_read  <= 1'b1;
      bus_write <= 1'b0;
      bus_wdata <= ACC_RESET;
    end else begin
      state     <= next_state;
      bus_addr  <= (next_state == CIS_BT_RD) ? bt_addr : next_addr;
      bus_read  <= next_read;
      bus_write <= next_write;
      bus_wdata <= (next_state == CIS_STA_WR) ? acc : ACC_RESET;
    end
  end

  // Program counter register
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      pc <= PC_RESET;
    else
      pc <= next_pc;
  end

  // Operand capture
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      opcode    <= 8'h00;
      addr_lo   <= 8'h00;
      test_byte <= 8'h00;
      offset    <= 8'h00;
    end else begin
      if (state == CIS_FETCH)
        opcode <= mem_rdata;
      if (state == CIS_STA_LO || state == CIS_BT_ADR)
        addr_lo <= mem_rdata;
      if (state == CIS_BT_RD)
        test_byte <= mem_rdata;
      if (state == CIS_BR_OFS || state == CIS_BT_OFS)
        offset <= mem_rdata;
    end
  end

  // Accumulator and flags; only N and Z move on a load
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc                 <= ACC_RESET;
      condition_flags_reg <= FLAGS_RESET;
    end else if (state == CIS_LDA_IMM) begin
      acc <= mem_rdata;
      condition_flags_reg[FLAG_Z_POS] <= (mem_rdata == 8'h00);
      condition_flags_reg[FLAG_N_POS] <= mem_rdata[7];
    end
  end

  // Unsupported opcodes park the sequencer; only reset recovers it
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      unknown_op <= 1'b0;
    else
      unknown_op <= (next_state == CIS_HALT);
  end
endmodule
`default_nettype wire

// ==== test/cis_mem_model.sv ====
// Zero-wait memory model on the internal bus.
`timescale 1ns/1ps
`default_nettype none
module cis_mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;
  initial last = 8'h00;
  always @(posedge core_clk) begin
    if (bus_write) mem[bus_addr[7:0]] <= bus_wdata;
    last <= mem_rdata;
  end
  // Unread cycles show the previous cycle's byte flipped, so a stale value is hidden on one unread cycle but returns on a second in a row
  assign mem_rdata = bus_read ? mem[bus_addr[7:0]] : ~last;
endmodule
`default_nettype wire

// ==== test/cis_sequencer_sva.sv ====
// Port checker for the instruction cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer_sva
  import cis_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic          core_clk,
  input wire logic          reset_n,
  input wire logic [7:0]    mem_rdata,
  input wire logic [AW-1:0] bus_addr,
  input wire logic [7:0]    bus_wdata,
  input wire logic          bus_write,
  input wire logic          bus_read,
  input wire logic [7:0]    acc,
  input wire logic [4:0]    condition_flags_reg,
  input wire logic [AW-1:0] pc,
  input wire logic          unknown_op
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_idle;
    !bus_write && !bus_read;
  endsequence
  sequence s_fetch;
    bus_read && !bus_write;
  endsequence
  a_write_then_fetch: assert property (bus_write |=> s_fetch) else $error("write strobe not one cycle");
  a_write_page: assert property (bus_write |-> bus_addr[15:8] == 8'h00) else $error("write outside page");
  a_write_acc: assert property (bus_write |-> bus_wdata == acc) else $error("write data not acc");
  a_build_gap: assert property (bus_write |-> !$past(bus_read)) else $error("no build cycle");
  a_addr_low_byte: assert property (bus_write |-> bus_addr[7:0] == $past(mem_rdata, 2))
    else $error("bad low byte");
  a_next_fetch_pc: assert property (bus_write |=> bus_addr == $past(pc)) else $error("bad next fetch");
  a_other_flags: assert property (condition_flags_reg[4:3] == 2'b00 && !condition_flags_reg[0])
    else $error("flag set");
  a_load_flags: assert property ($changed(acc) |-> condition_flags_reg[1] == (acc == 8'h00) && condition_flags_reg[2] == acc[7])
    else $error("flags not from acc");
  a_halt_idle: assert property (unknown_op |=> s_idle ##1 s_idle) else $error("bus busy in halt");
endmodule
bind cis_sequencer cis_sequencer_sva #(.AW(AW)) chk_u (.core_clk(core_clk), .reset_n(reset_n), .mem_rdata(mem_rdata),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .acc(acc),
  .condition_flags_reg(condition_flags_reg), .pc(pc), .unknown_op(unknown_op));
`default_nettype wire

// ==== test/cis_sequencer_tb.sv ====
// Self-checking bench for the instruction cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer_tb;
  import cis_pkg::*;
  logic core_clk = 0, reset_n = 0, bus_write, bus_read, unknown_op;
  logic [7:0] mem_rdata, bus_wdata, acc;
  logic [15:0] bus_addr, pc;
  logic [4:0] flags;
  int failures = 0, tests_run = 0;
  byte prog [] = '{8'ha6, 8'h80, 8'h2a, 8'h10, 8'ha6, 8'h00, 8'ha6, 8'h5a, 8'hb7, 8'h40, 8'h2a, 8'h02, 8'ha6, 8'hff,
    8'h0f, 8'h40, 8'h02, 8'ha6, 8'hff, 8'h03, 8'h40, 8'h02, 8'h02, 8'h40, 8'h03, 8'hff, 8'hff, 8'hff, 8'h2a, 8'h04,
    8'ha6, 8'h80, 8'hff, 8'hff, 8'h2a, 8'hfa};
  initial forever #5 core_clk = ~core_clk;
  cis_sequencer dut_u (.core_clk(core_clk), .reset_n(reset_n), .mem_rdata(mem_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .acc(acc), .condition_flags_reg(flags),
    .pc(pc), .unknown_op(unknown_op));
  cis_mem_model mem_u (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .mem_rdata(mem_rdata));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic adv(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_load(input logic [7:0] v, input logic [15:0] p, input logic [4:0] f);
    adv(2);
    chk("acc", acc, v);
    chk("pc", pc, p);
    chk("flags", flags, f);
  endtask
  task automatic t_store(input logic [15:0] p);
    adv(3);
    chk("wr", bus_write, 1);
    chk("addr", bus_addr, 16'h0040);
    chk("wdata", bus_wdata, 16'h005a);
    adv(1);
    chk("mem", mem_u.mem[8'h40], 16'h005a);
    chk("pc", pc, p);
  endtask
  task automatic t_branch(input logic [15:0] p);
    adv(3);
    chk("pc", pc, p);
  endtask
  task automatic t_bittest(input logic [15:0] p);
    adv(2);
    chk("tst", bus_addr, 16'h0040);
    adv(3);
    chk("pc", pc, p);
  endtask
  task automatic t_halt();
    int i;
    for (i = 0; i < 8 && unknown_op !== 1'b1; i++) adv(1);
    chk("halt", unknown_op, 1);
    adv(1);
    chk("rd", bus_read, 0);
  endtask
  initial begin
    foreach (prog[i]) mem_u.mem[i] = prog[i];
    adv(10);
    chk("pc0", pc, 16'h0000);
    reset_n = 1;
    t_load(8'h80, 16'h0002, 5'h04);
    t_branch(16'h0004);
    t_load(8'h00, 16'h0006, 5'h02);
    t_load(8'h5a, 16'h0008, 5'h00);
    t_store(16'h000a);
    t_branch(16'h000e);
    t_bittest(16'h0013);
    t_bittest(16'h0016);
    t_bittest(16'h001c);
    t_branch(16'h0022);
    t_branch(16'h001e);
    t_load(8'h80, 16'h0020, 5'h04);
    t_halt();
    finish_test();
  end
endmodule
`default_nettype wire
